//--- src/lao_pkg.sv
// Package of constants and carrier types for the lift auxiliary output logic.
package lao_pkg;

	// Clock rate and the daily test period.
	localparam int unsigned CLK_HZ           = 50_000_000;
	localparam longint unsigned DAY_S        = 86_400;
	localparam longint unsigned DAY_CYCLES   = DAY_S * CLK_HZ;
	// Inverter reset pulse length in milliseconds, and its count of cycles.
	localparam int unsigned INV_RST_MS       = 500;
	localparam int unsigned INV_RST_CYCLES   = INV_RST_MS * (CLK_HZ / 1000);
	// Width of the cycle counters.
	localparam int unsigned CNT_W            = 48;
	localparam logic [CNT_W-1:0] CNT_RESET   = 48'h0000_0000_0000;
	localparam logic OUT_RESET               = 1'b0;

	// States of the UPS test sequence.
	typedef enum logic [1:0]
	{
		UPS_IDLE    = 2'b00,
		UPS_REQUEST = 2'b01,
		UPS_DRIVE   = 2'b10,
		UPS_BLOCKED = 2'b11
	} lao_ups_state_t;

	// Inputs from the shaft sensors and the controller.
	typedef struct packed
	{
		logic level_upper;
		logic level_lower;
		logic inverter_fault;
		logic test_drive_done;
		logic test_drive_error;
	} lao_inputs_t;

endpackage

//--- src/lao_aux_outputs.sv
// Auxiliary output functions: daily UPS test, inverter reset and door zone.
`timescale 1ns/1ps
// Overview of operation
// - Test relay output interrupts UPS phase supply.
// - Daily, open UPS supply and test drive.
// - Error during test drive blocks lift.
// - Inverter fault asserts driver reset output.
// - Door zone on when both sensors active.
// - Door zone independent of motion state.
// - Door zone doubles as floor level indication.
module lao_aux_outputs
	import lao_pkg::*;
#(
	parameter longint unsigned DAY_LEN = DAY_CYCLES,
	parameter int unsigned     RST_LEN = INV_RST_CYCLES
)
(
	input  wire logic        core_clk,            // System clock, 50 MHz.
	input  wire logic        rstn,                // Asynchronous reset, active low.
	input  wire lao_inputs_t in_sig,              // Sensor and controller inputs.
	output logic             ups_test_relay_out,  // Relay opening UPS phase supply.
	output logic             test_drive_req,      // Asks controller for a UPS drive.
	output logic             lift_blocked,        // Lift operation inhibited.
	output logic             inverter_reset_out,  // Reset pulse to motor inverter.
	output logic             door_zone_out,       // Door unlocking zone.
	output logic             floor_level_out      // Floor level indication.
);

	lao_ups_state_t   state_ff, nxt_state;
	logic [CNT_W-1:0] day_cnt_ff, nxt_day_cnt;
	logic [CNT_W-1:0] rst_cnt_ff, nxt_rst_cnt;
	logic             relay_ff, nxt_relay;
	logic             req_ff, nxt_req;
	logic             blk_ff, nxt_blk;
	logic             inv_ff, nxt_inv;
	logic             zone_ff, nxt_zone;

	// True on the last count of the day; the sequence and its check share it.
	function automatic logic day_expired(input logic [CNT_W-1:0] cnt);
		return cnt >= CNT_W'(DAY_LEN - 1);
	endfunction

	// Daily timer and UPS test sequence; the blocked state is left only by reset.
	always_comb
	begin
		nxt_state   = state_ff;
		nxt_day_cnt = day_cnt_ff;
		nxt_relay   = OUT_RESET;
		nxt_req     = OUT_RESET;
		nxt_blk     = blk_ff;
		case (state_ff)
			UPS_IDLE:
			begin
				if (day_expired(day_cnt_ff))
				begin
					nxt_day_cnt = CNT_RESET;
					nxt_state   = UPS_REQUEST;
					nxt_relay   = 1'b1;
				end
				else
				begin
					nxt_day_cnt = day_cnt_ff + CNT_W'(1);
				end
			end
			UPS_REQUEST, UPS_DRIVE:
			begin
				nxt_relay = 1'b1;
				nxt_req   = 1'b1;
				nxt_state = UPS_DRIVE;
				if (in_sig.test_drive_error)
				begin
					nxt_state = UPS_BLOCKED;
					nxt_relay = 1'b0;
					nxt_req   = 1'b0;
					nxt_blk   = 1'b1;
				end
				else if (state_ff == UPS_DRIVE && in_sig.test_drive_done)
				begin
					nxt_state = UPS_IDLE;
					nxt_relay = 1'b0;
					nxt_req   = 1'b0;
				end
			end
			UPS_BLOCKED:
			begin
				nxt_blk = 1'b1;
			end
			default:
			begin
				nxt_state = UPS_IDLE;
			end
		endcase
	end

	// Inverter reset pulse: a fault starts a pulse of fixed length.
	always_comb
	begin
		nxt_inv     = inv_ff;
		nxt_rst_cnt = rst_cnt_ff;
		if (inv_ff)
		begin
			if (rst_cnt_ff >= CNT_W'(RST_LEN - 1))
			begin
				nxt_inv     = 1'b0;
				nxt_rst_cnt = CNT_RESET;
			end
			else
			begin
				nxt_rst_cnt = rst_cnt_ff + CNT_W'(1);
			end
		end
		else if (in_sig.inverter_fault)
		begin
			nxt_inv     = 1'b1;
			nxt_rst_cnt = CNT_RESET;
		end
	end

	// Door zone from both levelling sensors, ignoring motion.
	always_comb
	begin
		nxt_zone = in_sig.level_upper & in_sig.level_lower;
	end

	// Registers for all groups; every output is forced inactive in reset.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_ff   <= UPS_IDLE;
			day_cnt_ff <= CNT_RESET;
			rst_cnt_ff <= CNT_RESET;
			relay_ff   <= OUT_RESET;
			req_ff     <= OUT_RESET;
			blk_ff     <= OUT_RESET;
			inv_ff     <= OUT_RESET;
			zone_ff    <= OUT_RESET;
		end
		else
		begin
			state_ff   <= nxt_state;
			day_cnt_ff <= nxt_day_cnt;
			rst_cnt_ff <= nxt_rst_cnt;
			relay_ff   <= nxt_relay;
			req_ff     <= nxt_req;
			blk_ff     <= nxt_blk;
			inv_ff     <= nxt_inv;
			zone_ff    <= nxt_zone;
		end
	end

	assign ups_test_relay_out = relay_ff;
	assign test_drive_req     = req_ff;
	assign lift_blocked       = blk_ff;
	assign inverter_reset_out = inv_ff;
	assign door_zone_out      = zone_ff;
	assign floor_level_out    = zone_ff;

	// Day expiry while idle is the start of the test.
	sequence s_day_expiry;
		state_ff == UPS_IDLE && day_expired(day_cnt_ff);
	endsequence

	// Relay opens one cycle after the day timer expires.
	property p_relay_daily;
		@(posedge core_clk) disable iff (!rstn)
		s_day_expiry |=> ups_test_relay_out;
	endproperty
	a_relay_daily: assert property (p_relay_daily) else $error("Relay not opened");

	// The drive is requested one cycle after the relay opens, unless an error blocked it.
	sequence s_relay_then_req;
		ups_test_relay_out ##1 (test_drive_req || lift_blocked);
	endsequence
	property p_req_follows;
		@(posedge core_clk) disable iff (!rstn)
		s_day_expiry |=> s_relay_then_req;
	endproperty
	a_req_follows: assert property (p_req_follows) else $error("Drive not requested");

	// Relay stays open while the test drive runs.
	property p_relay_drive;
		@(posedge core_clk) disable iff (!rstn)
		(state_ff == UPS_DRIVE) |-> ups_test_relay_out;
	endproperty
	a_relay_drive: assert property (p_relay_drive) else $error("Relay closed in drive");

	// Error during the drive leads to blocking next cycle.
	sequence s_drive_err;
		(state_ff == UPS_DRIVE || state_ff == UPS_REQUEST) && in_sig.test_drive_error;
	endsequence
	property p_block_on_err;
		@(posedge core_clk) disable iff (!rstn)
		s_drive_err |=> lift_blocked ##1 lift_blocked;
	endproperty
	a_block_on_err: assert property (p_block_on_err) else $error("Not blocked");

	// Blocked state never clears outside reset.
	property p_block_sticky;
		@(posedge core_clk) disable iff (!rstn)
		lift_blocked |=> lift_blocked;
	endproperty
	a_block_sticky: assert property (p_block_sticky) else $error("Block cleared");

	// A blocked lift neither opens the relay nor requests a drive.
	property p_blocked_quiet;
		@(posedge core_clk) disable iff (!rstn)
		lift_blocked |-> !ups_test_relay_out && !test_drive_req;
	endproperty
	a_blocked_quiet: assert property (p_blocked_quiet) else $error("Blocked lift active");

	// Fault while idle starts the inverter reset next cycle.
	property p_inv_reset;
		@(posedge core_clk) disable iff (!rstn)
		(in_sig.inverter_fault && !inverter_reset_out) |=> inverter_reset_out;
	endproperty
	a_inv_reset: assert property (p_inv_reset) else $error("No inverter reset");

	// Door zone follows both sensors one cycle later.
	property p_zone;
		@(posedge core_clk) disable iff (!rstn)
		1'b1 |=> (door_zone_out == ($past(in_sig.level_upper) & $past(in_sig.level_lower)));
	endproperty
	a_zone: assert property (p_zone) else $error("Door zone wrong");

	// Single sensor never shows the zone.
	property p_zone_single;
		@(posedge core_clk) disable iff (!rstn)
		(in_sig.level_upper != in_sig.level_lower) |=> !door_zone_out;
	endproperty
	a_zone_single: assert property (p_zone_single) else $error("Zone on one sensor");

	// Floor level indication equals the door zone.
	property p_floor;
		@(posedge core_clk) disable iff (!rstn)
		floor_level_out == door_zone_out;
	endproperty
	a_floor: assert property (p_floor) else $error("Floor level differs");

endmodule

//--- tb/lao_partner.sv
// Behavioural controller that runs the UPS test drive and reports how it ended.
`timescale 1ns/1ps
module lao_partner
(
	input  wire logic       core_clk, // System clock.
	input  wire logic       relay,    // UPS supply opened by the block.
	input  wire logic [7:0] delay,    // Drive length in cycles.
	input  wire logic       err_mode, // Report an error instead of success.
	output logic            done,     // Drive finished.
	output logic            error     // Drive failed.
);
	logic [7:0] cnt_ff = 8'h00;
	// Count drive time while the supply is open; the report drops with the relay.
	always @(posedge core_clk)
		cnt_ff <= #1 relay ? cnt_ff + 8'h01 : 8'h00;
	assign done  = relay && cnt_ff >= delay && !err_mode;
	assign error = relay && cnt_ff >= delay && err_mode;
endmodule

//--- tb/lao_aux_outputs_tb.sv
// Self-checking bench for the lift auxiliary output logic.
`timescale 1ns/1ps
module lao_aux_outputs_tb;
	import lao_pkg::*;
	localparam int DAY = 20;
	localparam int RST = 4;
	logic        core_clk;
	logic        rstn;
	logic        lu, ll, flt, dn, er, err_mode, relay, req, blk, inv, dz, fl;
	logic [7:0]  dly;
	logic [31:0] seed;
	logic [5:0]  e, x;
	logic [5:0]  q[$];
	lao_inputs_t ins;
	int          st, p, dcnt, icnt, i, bad_count, samples_checked;
	assign ins = {lu, ll, flt, dn, er};
	lao_aux_outputs #(.DAY_LEN(DAY), .RST_LEN(RST)) DUT
	(
		.core_clk(core_clk), .rstn(rstn), .in_sig(ins), .ups_test_relay_out(relay),
		.test_drive_req(req), .lift_blocked(blk), .inverter_reset_out(inv),
		.door_zone_out(dz), .floor_level_out(fl)
	);
	lao_partner PTR
	(
		.core_clk(core_clk), .relay(relay), .delay(dly), .err_mode(err_mode),
		.done(dn), .error(er)
	);
	// Free-running system clock.
	initial
	begin
		core_clk = 1'h0;
		forever #10 core_clk = ~core_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	// Random sensor and fault levels, applied just after each edge.
	task step(input int n);
		repeat (n)
		begin
			@(posedge core_clk);
			#1;
			seed = xs(seed);
			{lu, ll} = seed[1:0];
			flt = &seed[6:4];
		end
	endtask
	task chk(input string n, input logic [2:0] ex, input logic [2:0] s);
		samples_checked++;
		if (s !== ex)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, ex, s);
		end
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Reference model: notes the outputs expected after every edge.
	always @(posedge core_clk)
	begin
		p = st;
		if (!rstn)
			st = 0;
		else if (st == 0)
			st = (dcnt == DAY - 1) ? 1 : 0;
		else if (st != 3)
			st = er ? 3 : ((st == 2 && dn) ? 0 : 2);
		dcnt = (rstn && p == 0 && st == 0) ? dcnt + 1 : 0;
		if (!rstn)
			icnt = 0;
		else if (icnt > 0)
			icnt--;
		else if (flt)
			icnt = RST;
		e = {st == 1 || st == 2, st == 2, st == 3, icnt > 0, lu & ll, lu & ll};
		q.push_back(rstn ? e : 6'h00);
	end
	// Monitor: takes the oldest note and compares it with the settled outputs.
	always @(negedge core_clk)
		if (q.size() > 0)
		begin
			x = q.pop_front();
			if (!rstn)
				x = 6'h00;
			chk("ups", x[5:3], {relay, req, blk});
			chk("inverter", {2'h0, x[2]}, {2'h0, inv});
			chk("door zone", {1'h0, x[1:0]}, {1'h0, dz, fl});
		end
	// Prompt drive, slow drive, error in the request cycle, reset, error in drive.
	initial
	begin
		{rstn, lu, ll, flt, err_mode} = 5'h00;
		{dly, st, dcnt, icnt, bad_count, samples_checked} = 0;
		seed = 32'h0000_0031;
		step(20);
		rstn = 1'h1;
		step(60);
		dly = 8'h09;
		step(60);
		err_mode = 1'h1;
		dly = 8'h00;
		for (i = 0; i < 100 && blk !== 1'h1; i++)
			step(1);
		if (i == 100)
			bad_count++;
		else
		begin
			step(40);
			rstn = 1'h0;
			step(3);
			rstn = 1'h1;
			dly = 8'h04;
			step(60);
		end
		wrap_up();
	end
endmodule
